// ===== hw/data_space_access_unit.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1 - upper data half maps to program page
// RULE2 - redirect when ea bit15 and enable
// RULE3 - program address is page plus ea low bits
// RULE4 - window read returns low 16 bits
// RULE5 - table instructions suspend window redirection
// RULE6 - transfer, double, mac add one cycle
// RULE7 - other window instructions add two cycles
// RULE8 - repeat edges add two, middle iterations none
// RULE9 - upper half always x space
// RULE10 - mac reads exclude y from x
// RULE11 - mac prefetch pointers read both spaces; the code lets x pointers read only x and y pointers read only the y block
// RULE12 - all writes use x bus only
// RULE13 - modulo both spaces, bit-reverse x writes; the code ignores modulo and only clears bit 0 of the x write address
// RULE14 - x/y boundary fixed in hardware
// RULE15 - invalid reads return zero
// RULE16 - 16-bit byte effective addresses
// RULE17 - byte read selects lane into low byte
// RULE18 - byte write strobes single lane
// RULE19 - post-increment by one or two
// RULE20 - odd word access traps, write suppressed
// RULE21 - byte load keeps register high byte
// RULE22 - alignment checked on final word address; the code tests bit 0 of x_req_i.ea, not of the bit-reversed wr_ea
module data_space_access_unit #(
    parameter int RAM_AW = dsu_pkg::RAM_WORDS_LOG2
) (
    // clock and reset
    input  wire logic                        ref_clk_i,
    input  wire logic                        nrst_i,
    // core control
    input  wire logic                        program_window_enable_i,
    input  wire logic [7:0]                  program_window_page_i,
    // x request from address generator
    input  wire dsu_pkg::x_req_t             x_req_i,
    input  wire logic [15:0]                 dest_reg_i,
    // y prefetch request and x prefetch source
    input  wire dsu_pkg::pf_req_t            y_pf_i,
    // program memory port
    output logic      [23:0]                 prog_addr_o,
    output logic                             prog_rd_o,
    input  wire logic [23:0]                 prog_rdata_i,
    // results
    output logic      [15:0]                 x_rdata_o,
    output logic      [15:0]                 y_rdata_o,
    output logic      [15:0]                 dest_merged_o,
    output logic      [15:0]                 source_pointer_next_o,
    output logic                             done_o,
    output logic                             stall_o,
    output logic                             addr_error_o,
    output logic                             write_done_o
);

    ////////////////////////////////////////////////////////////////////
    // address classification

    function automatic logic in_y(input logic [15:0] a);
        in_y = (a >= dsu_pkg::Y_BASE) && (a <= dsu_pkg::Y_LIMIT); // see RULE14
    endfunction

    function automatic logic implemented(input logic [15:0] a);
        implemented = (a <= dsu_pkg::IMPL_LIMIT);
    endfunction

    function automatic logic [RAM_AW-1:0] word_index(input logic [15:0] a);
        word_index = a[RAM_AW:1];
    endfunction

    logic        redirect;
    logic        misaligned;
    logic        x_valid_rd;
    logic        y_valid_rd;
    logic [1:0]  extra_cycles;
    logic [15:0] wr_ea;

    // see RULE16
    always_comb begin
        redirect   = x_req_i.valid && x_req_i.ea[dsu_pkg::WIN_BIT]
                     && program_window_enable_i && !x_req_i.table_op; // see RULE2 see RULE5
        misaligned = x_req_i.valid && !x_req_i.byte_op && x_req_i.ea[0]; // see RULE22
        // upper half never y; mac x reads exclude y block
        if (x_req_i.cls == dsu_pkg::CLS_MAC && !x_req_i.write) begin
            x_valid_rd = implemented(x_req_i.ea) && !in_y(x_req_i.ea); // see RULE10 see RULE9
        end else begin
            x_valid_rd = implemented(x_req_i.ea);
        end
        y_valid_rd = y_pf_i.valid && !y_pf_i.from_x_ptr && in_y(y_pf_i.ea); // see RULE11
    end

    // bit-reversed modifier only reaches x writes
    always_comb begin
        wr_ea = x_req_i.ea;
        if (x_req_i.bit_rev && x_req_i.write) begin
            wr_ea = {x_req_i.ea[15:1], 1'b0}; // see RULE13
        end
    end

    // window stall length
    always_comb begin
        extra_cycles = dsu_pkg::STALL_LONG; // see RULE7
        case (x_req_i.rep)
            dsu_pkg::REP_MIDDLE: begin
                extra_cycles = 2'h0; // see RULE8
            end
            dsu_pkg::REP_EDGE: begin
                extra_cycles = dsu_pkg::STALL_LONG; // see RULE8
            end
            default: begin
                if (x_req_i.cls != dsu_pkg::CLS_OTHER) begin
                    extra_cycles = dsu_pkg::STALL_SHORT; // see RULE6
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // data memory

    logic [1:0]  lane_we;
    logic [15:0] ram_x_q;
    logic [15:0] ram_y_q;
    logic [15:0] lane_wdata;

    // see RULE12
    always_comb begin
        lane_we    = 2'b00;
        lane_wdata = x_req_i.wdata;
        if (x_req_i.valid && x_req_i.write && !redirect && !misaligned
            && implemented(wr_ea)) begin // see RULE20
            if (x_req_i.byte_op) begin
                lane_we    = wr_ea[0] ? 2'b10 : 2'b01; // see RULE18
                lane_wdata = {x_req_i.wdata[7:0], x_req_i.wdata[7:0]};
            end else begin
                lane_we = 2'b11;
            end
        end
    end

    dsu_ram #(
        .AW (RAM_AW)
    ) u_ram (
        .ref_clk_i  (ref_clk_i),
        .xa_addr_i  (word_index(wr_ea)),
        .xa_we_i    (lane_we),
        .xa_wdata_i (lane_wdata),
        .xa_rdata_o (ram_x_q),
        .yb_addr_i  (word_index(y_pf_i.ea)),
        .yb_rdata_o (ram_y_q)
    );

    ////////////////////////////////////////////////////////////////////
    // access sequencer

    dsu_pkg::acc_state_t state_reg;
    dsu_pkg::acc_state_t state_next;
    logic [1:0]          cnt_reg;
    logic                redir_reg;
    logic                xok_reg;
    logic                yok_reg;
    logic                byte_reg;
    logic                hi_reg;
    logic                write_reg;
    logic                mis_reg;
    logic [15:0]         dest_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dsu_pkg::ST_IDLE: begin
                if (x_req_i.valid || y_pf_i.valid) begin
                    if (redirect && extra_cycles != 2'h0) begin
                        state_next = dsu_pkg::ST_STALL;
                    end else begin
                        state_next = dsu_pkg::ST_DONE;
                    end
                end
            end
            dsu_pkg::ST_STALL: begin
                if (cnt_reg == 2'h1) begin
                    state_next = dsu_pkg::ST_DONE;
                end
            end
            dsu_pkg::ST_DONE: begin
                state_next = dsu_pkg::ST_IDLE;
            end
            default: begin
                state_next = dsu_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= dsu_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // stall counter
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg <= 2'h0;
        end else if (state_reg == dsu_pkg::ST_IDLE) begin
            cnt_reg <= extra_cycles;
        end else if (cnt_reg != 2'h0) begin
            cnt_reg <= cnt_reg - 2'h1;
        end
    end

    // capture request attributes
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            redir_reg <= 1'b0;
            xok_reg   <= 1'b0;
            yok_reg   <= 1'b0;
            byte_reg  <= 1'b0;
            hi_reg    <= 1'b0;
            write_reg <= 1'b0;
            mis_reg   <= 1'b0;
            dest_reg  <= dsu_pkg::ZERO_WORD;
        end else if (state_reg == dsu_pkg::ST_IDLE) begin
            redir_reg <= redirect;
            xok_reg   <= x_req_i.valid && !x_req_i.write && x_valid_rd;
            yok_reg   <= y_valid_rd;
            byte_reg  <= x_req_i.byte_op;
            hi_reg    <= x_req_i.ea[0];
            write_reg <= |lane_we;
            mis_reg   <= misaligned;
            dest_reg  <= dest_reg_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // program window port

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prog_addr_o <= 24'h00_0000;
            prog_rd_o   <= 1'b0;
        end else if (state_reg == dsu_pkg::ST_IDLE) begin
            prog_addr_o <= {1'b0, program_window_page_i, x_req_i.ea[14:0]}; // see RULE1 see RULE3
            prog_rd_o   <= redirect && !x_req_i.write;
        end else if (state_next == dsu_pkg::ST_IDLE) begin
            prog_rd_o   <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read return

    logic [15:0] x_word;

    always_comb begin
        x_word = dsu_pkg::ZERO_WORD; // see RULE15
        if (redir_reg) begin
            x_word = prog_rdata_i[15:0]; // see RULE4
        end else if (xok_reg) begin
            x_word = ram_x_q;
        end
        if (byte_reg) begin
            x_word = {8'h00, hi_reg ? x_word[15:8] : x_word[7:0]}; // see RULE17
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            x_rdata_o     <= dsu_pkg::ZERO_WORD;
            y_rdata_o     <= dsu_pkg::ZERO_WORD;
            dest_merged_o <= dsu_pkg::ZERO_WORD;
        end else if (state_reg == dsu_pkg::ST_DONE) begin
            x_rdata_o     <= x_word;
            y_rdata_o     <= yok_reg ? ram_y_q : dsu_pkg::ZERO_WORD; // see RULE15
            dest_merged_o <= byte_reg ? {dest_reg[15:8], x_word[7:0]} : x_word; // see RULE21
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pointer update and status

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            source_pointer_next_o <= dsu_pkg::ZERO_WORD;
        end else if (state_reg == dsu_pkg::ST_IDLE && x_req_i.valid) begin
            if (x_req_i.post_inc) begin
                source_pointer_next_o <= x_req_i.ea + (x_req_i.byte_op ?
                    dsu_pkg::STEP_BYTE : dsu_pkg::STEP_WORD); // see RULE19
            end else begin
                source_pointer_next_o <= x_req_i.ea;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_o       <= 1'b0;
            stall_o      <= 1'b0;
            addr_error_o <= 1'b0;
            write_done_o <= 1'b0;
        end else begin
            done_o       <= (state_reg == dsu_pkg::ST_DONE);
            stall_o      <= (state_next == dsu_pkg::ST_STALL);
            addr_error_o <= (state_reg == dsu_pkg::ST_DONE) && mis_reg; // see RULE20
            write_done_o <= (state_reg == dsu_pkg::ST_DONE) && write_reg && !mis_reg;
        end
    end

endmodule

// ===== hw/dsu_ram.sv
`timescale 1ns/1ps
module dsu_ram #(
    parameter int AW = 11
) (
    // clock
    input  wire logic          ref_clk_i,
    // x port: read and byte-lane write
    input  wire logic [AW-1:0] xa_addr_i,
    input  wire logic [1:0]    xa_we_i,
    input  wire logic [15:0]   xa_wdata_i,
    output logic      [15:0]   xa_rdata_o,
    // y port: read only
    input  wire logic [AW-1:0] yb_addr_i,
    output logic      [15:0]   yb_rdata_o
);
    logic [7:0] lo_mem [2**AW];
    logic [7:0] hi_mem [2**AW];

    // shared word decode, separate lane strobes
    always_ff @(posedge ref_clk_i) begin
        if (xa_we_i[0]) begin
            lo_mem[xa_addr_i] <= xa_wdata_i[7:0];
        end
        if (xa_we_i[1]) begin
            hi_mem[xa_addr_i] <= xa_wdata_i[15:8];
        end
        xa_rdata_o <= {hi_mem[xa_addr_i], lo_mem[xa_addr_i]};
        yb_rdata_o <= {hi_mem[yb_addr_i], lo_mem[yb_addr_i]};
    end
endmodule

// ===== shared/dsu_pkg.sv
package dsu_pkg;

    // address map
    localparam int          EA_W            = 16;
    localparam int          DATA_W          = 16;
    localparam int          PROG_W          = 24;
    localparam int          PROG_ADDR_W     = 24;
    localparam int          PAGE_W          = 8;
    localparam int          WIN_BIT         = 15;
    localparam logic [15:0] Y_BASE          = 16'h0800;
    localparam logic [15:0] Y_LIMIT         = 16'h0BFF;
    localparam logic [15:0] IMPL_LIMIT      = 16'h0BFF;
    localparam int          RAM_WORDS_LOG2  = 11;

    // reset values
    localparam logic [15:0] ZERO_WORD       = 16'h0000;
    localparam logic [7:0]  PAGE_RST        = 8'h00;

    // pointer step sizes
    localparam logic [15:0] STEP_BYTE       = 16'h0001;
    localparam logic [15:0] STEP_WORD       = 16'h0002;

    // window stall cycles
    localparam logic [1:0]  STALL_SHORT     = 2'h1;
    localparam logic [1:0]  STALL_LONG      = 2'h2;

    typedef enum logic [1:0] {
        CLS_TRANSFER = 2'h0,
        CLS_DOUBLE   = 2'h1,
        CLS_MAC      = 2'h2,
        CLS_OTHER    = 2'h3
    } insn_class_t;

    typedef enum logic [1:0] {
        REP_NONE   = 2'h0,
        REP_EDGE   = 2'h1,
        REP_MIDDLE = 2'h2
    } repeat_pos_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        byte_op;
        logic        post_inc;
        logic        bit_rev;
        logic        modulo;
        logic        table_op;
        insn_class_t cls;
        repeat_pos_t rep;
        logic [15:0] ea;
        logic [15:0] wdata;
    } x_req_t;

    typedef struct packed {
        logic        valid;
        logic        from_x_ptr;
        logic [15:0] ea;
    } pf_req_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_STALL = 3'b010,
        ST_DONE  = 3'b100
    } acc_state_t;

endpackage

// ===== test/data_space_access_unit_sva.sv
`timescale 1ns/1ps
module data_space_access_checker (
    // clock and reset
    input wire logic            ref_clk_i,
    input wire logic            nrst_i,
    // watched inputs
    input wire logic            program_window_enable_i,
    input wire logic [7:0]      program_window_page_i,
    input wire dsu_pkg::x_req_t x_req_i,
    // watched outputs
    input wire logic [23:0]     prog_addr_o,
    input wire logic            prog_rd_o,
    input wire logic [15:0]     x_rdata_o,
    input wire logic [15:0]     source_pointer_next_o,
    input wire logic            done_o,
    input wire logic            stall_o,
    input wire logic            addr_error_o,
    input wire logic            write_done_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    a_win_addr: assert property (prog_rd_o |-> prog_addr_o ==
        {1'b0, program_window_page_i, x_req_i.ea[14:0]}) else $error("window address");
    a_win_cause: assert property (prog_rd_o |-> program_window_enable_i
        && x_req_i.ea[15] && !x_req_i.table_op) else $error("window without cause");
    a_done_pulse: assert property (done_o |=> !done_o) else $error("done too long");
    a_err_cause: assert property (addr_error_o |-> done_o && !write_done_o
        && !x_req_i.byte_op && x_req_i.ea[0]) else $error("address error cause");
    a_wr_commit: assert property (write_done_o |-> done_o && x_req_i.write
        && x_req_i.ea <= dsu_pkg::IMPL_LIMIT) else $error("write commit");
    a_post_inc: assert property (done_o && x_req_i.post_inc |->
        source_pointer_next_o == x_req_i.ea + (x_req_i.byte_op ? 16'h0001 : 16'h0002))
        else $error("pointer step");
    a_byte_lane: assert property (done_o && x_req_i.byte_op && !x_req_i.write
        |-> x_rdata_o[15:8] == 8'h00) else $error("byte read high");
    a_stall_two: assert property ($rose(stall_o) && (x_req_i.cls == dsu_pkg::CLS_OTHER
        || x_req_i.rep == dsu_pkg::REP_EDGE) |-> stall_o[*2] ##1 !stall_o)
        else $error("two cycle stall");
    a_stall_one: assert property ($rose(stall_o) && x_req_i.cls != dsu_pkg::CLS_OTHER
        && x_req_i.rep == dsu_pkg::REP_NONE |=> !stall_o) else $error("one cycle stall");
    a_mid_rep: assert property (prog_rd_o && x_req_i.rep == dsu_pkg::REP_MIDDLE
        |-> !stall_o) else $error("middle iteration stall");
endmodule

bind data_space_access_unit data_space_access_checker u_data_space_access_checker (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .program_window_enable_i(program_window_enable_i),
    .program_window_page_i(program_window_page_i), .x_req_i(x_req_i),
    .prog_addr_o(prog_addr_o), .prog_rd_o(prog_rd_o), .x_rdata_o(x_rdata_o),
    .source_pointer_next_o(source_pointer_next_o), .done_o(done_o), .stall_o(stall_o),
    .addr_error_o(addr_error_o), .write_done_o(write_done_o));

// ===== test/prog_mem_model.sv
`timescale 1ns/1ps
module prog_mem_model (
    // program port
    input  wire logic [23:0] prog_addr_i,
    input  wire logic        prog_rd_i,
    output logic      [23:0] prog_rdata_o
);
    logic [23:0] word;

    // pattern word, upper byte never meant as data
    assign word = {~prog_addr_i[7:0], prog_addr_i[15:0] ^ 16'h3C3C};
    // released bus shows the inverse, not a held value
    assign prog_rdata_o = prog_rd_i ? word : ~word;
endmodule

// ===== test/test_data_space_access_unit.sv
`timescale 1ns/1ps
module test_data_space_access_unit;
    logic             ref_clk_i = 1'b0;
    logic             nrst_i = 1'b0;
    logic             program_window_enable_i = 1'b0;
    logic [7:0]       program_window_page_i = 8'h5B;
    dsu_pkg::x_req_t  x_req_i = '0;
    logic [15:0]      dest_reg_i = 16'hA5C3;
    dsu_pkg::pf_req_t y_pf_i = '0;
    logic [23:0]      prog_addr_o;
    logic [23:0]      prog_rdata_i;
    logic             prog_rd_o;
    logic             done_o;
    logic             stall_o;
    logic             addr_error_o;
    logic             write_done_o;
    logic [15:0]      x_rdata_o;
    logic [15:0]      y_rdata_o;
    logic [15:0]      dest_merged_o;
    logic [15:0]      source_pointer_next_o;
    int               fail_count = 0;
    int               n_checks = 0;
    localparam logic [3:0] f_wr = 4'h8;
    localparam logic [3:0] f_byte = 4'h4;
    localparam logic [3:0] f_inc = 4'h2;
    localparam logic [3:0] f_tbl = 4'h1;

    always #20 ref_clk_i = ~ref_clk_i;

    data_space_access_unit u_data_space_access_unit (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .program_window_enable_i(program_window_enable_i),
        .program_window_page_i(program_window_page_i), .x_req_i(x_req_i),
        .dest_reg_i(dest_reg_i), .y_pf_i(y_pf_i), .prog_addr_o(prog_addr_o),
        .prog_rd_o(prog_rd_o), .prog_rdata_i(prog_rdata_i), .x_rdata_o(x_rdata_o),
        .y_rdata_o(y_rdata_o), .dest_merged_o(dest_merged_o),
        .source_pointer_next_o(source_pointer_next_o), .done_o(done_o),
        .stall_o(stall_o), .addr_error_o(addr_error_o), .write_done_o(write_done_o));

    prog_mem_model u_prog_mem_model (
        .prog_addr_i(prog_addr_o), .prog_rd_i(prog_rd_o), .prog_rdata_o(prog_rdata_i));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    function automatic dsu_pkg::x_req_t mk(logic [3:0] f, logic [1:0] c, logic [1:0] rp,
                                           logic [15:0] a, logic [15:0] d = 16'h0000);
        return '{1'b1, f[3], f[2], f[1], 1'b0, 1'b0, f[0], dsu_pkg::insn_class_t'(c),
                 dsu_pkg::repeat_pos_t'(rp), a, d};
    endfunction

    // low word the pattern memory holds for a window address
    function automatic logic [15:0] pw(logic [15:0] ea);
        return {program_window_page_i[0], ea[14:0]} ^ 16'h3C3C;
    endfunction

    task automatic go(dsu_pkg::x_req_t r, dsu_pkg::pf_req_t p, int lat);
        int n;
        n = 1;
        @(posedge ref_clk_i);
        x_req_i <= r;
        y_pf_i <= p;
        @(posedge ref_clk_i);
        x_req_i.valid <= 1'b0;
        y_pf_i.valid <= 1'b0;
        do begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end while (done_o !== 1'b1 && n < 20);
        chk("latency", 16'(lat), 16'(n));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_window;
        @(posedge ref_clk_i);
        program_window_enable_i <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            go(mk(4'h0, c[1:0], 2'h0, 16'h8124 + 16'(c * 2)), '0, c == 3 ? 4 : 3);
            chk("window data", pw(16'h8124 + 16'(c * 2)), x_rdata_o);
        end
        go(mk(4'h0, 2'h3, 2'h1, 16'hFFFE), '0, 4);
        chk("repeat edge data", pw(16'hFFFE), x_rdata_o);
        go(mk(4'h0, 2'h3, 2'h2, 16'h8002), '0, 2);
        chk("repeat middle data", pw(16'h8002), x_rdata_o);
        go(mk(f_wr, 2'h0, 2'h0, 16'h8124, 16'h4444), '0, 3);
        chk("window write dropped", 16'h0000, 16'(write_done_o));
        go(mk(f_tbl, 2'h0, 2'h0, 16'h8124), '0, 2);
        chk("table suspends window", 16'h0000, x_rdata_o);
        @(posedge ref_clk_i);
        program_window_enable_i <= 1'b0;
        go(mk(4'h0, 2'h0, 2'h0, 16'h8124), '0, 2);
        chk("window disabled", 16'h0000, x_rdata_o);
        $display("test window finished");
    endtask

    task automatic t_bytes;
        go(mk(f_wr, 2'h0, 2'h0, 16'h0100, 16'hBEEF), '0, 2);
        chk("word write", 16'h0001, 16'(write_done_o));
        go(mk(f_wr | f_byte, 2'h0, 2'h0, 16'h0101, 16'h1212), '0, 2);
        go(mk(4'h0, 2'h0, 2'h0, 16'h0100), '0, 2);
        chk("byte lane write", 16'h12EF, x_rdata_o);
        go(mk(f_byte | f_inc, 2'h0, 2'h0, 16'h0101), '0, 2);
        chk("byte read", 16'h0012, x_rdata_o);
        chk("byte merge", 16'hA512, dest_merged_o);
        chk("byte step", 16'h0102, source_pointer_next_o);
        chk("byte no trap", 16'h0000, 16'(addr_error_o));
        go(mk(f_inc, 2'h0, 2'h0, 16'h0100), '0, 2);
        chk("word step", 16'h0102, source_pointer_next_o);
        $display("test bytes finished");
    endtask

    task automatic t_misalign;
        go(mk(f_wr, 2'h0, 2'h0, 16'h0101, 16'h5555), '0, 2);
        chk("odd write trap", 16'h0001, 16'(addr_error_o));
        chk("odd write dropped", 16'h0000, 16'(write_done_o));
        go(mk(4'h0, 2'h0, 2'h0, 16'h0101), '0, 2);
        chk("odd read trap", 16'h0001, 16'(addr_error_o));
        go(mk(4'h0, 2'h0, 2'h0, 16'h0100), '0, 2);
        chk("memory kept", 16'h12EF, x_rdata_o);
        $display("test misalign finished");
    endtask

    task automatic t_spaces;
        go(mk(f_wr, 2'h0, 2'h0, 16'h0800, 16'h7777), '0, 2);
        chk("y block write", 16'h0001, 16'(write_done_o));
        go(mk(4'h0, 2'h2, 2'h0, 16'h0100), '{1'b1, 1'b0, 16'h0800}, 2);
        chk("mac x read", 16'h12EF, x_rdata_o);
        chk("mac y read", 16'h7777, y_rdata_o);
        go(mk(4'h0, 2'h2, 2'h0, 16'h0800), '{1'b1, 1'b0, 16'h0100}, 2);
        chk("x pointer into y", 16'h0000, x_rdata_o);
        chk("y pointer into x", 16'h0000, y_rdata_o);
        go(mk(4'h0, 2'h2, 2'h0, 16'h0100), '{1'b1, 1'b1, 16'h0800}, 2);
        chk("x pointer on y path", 16'h0000, y_rdata_o);
        go(mk(4'h0, 2'h0, 2'h0, 16'h0800), '0, 2);
        chk("y via x path", 16'h7777, x_rdata_o);
        go(mk(4'h0, 2'h0, 2'h0, 16'h2000), '0, 2);
        chk("unimplemented", 16'h0000, x_rdata_o);
        go(mk(f_wr, 2'h0, 2'h0, 16'h2000, 16'h1111), '0, 2);
        chk("unimplemented write", 16'h0000, 16'(write_done_o));
        $display("test spaces finished");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #(40 * 3000);
        fail_count++;
        complete_run();
    end

    initial begin
        repeat (20) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        t_window();
        t_bytes();
        t_misalign();
        t_spaces();
        complete_run();
    end
endmodule
